// ---- hw/fmirq_pkg.sv ----
package fmirq_pkg;

  // ---------------------------------------------------------------
  // Register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_ADDR      = 8'h04;
  localparam logic [7:0] MASK_ADDR      = 8'h05;
  localparam logic [7:0] STAT_ADDR      = 8'h06;
  localparam int         MODE_SRST_BIT  = 6;
  localparam int         MODE_LPREQ_BIT = 7;
  localparam logic [7:0] MASK_RESET     = 8'hff;
  localparam logic [7:0] STAT_RESET     = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Event positions in mask and status
  localparam int EVT_INDICATOR_LED = 0;
  localparam int EVT_TRANSFORMER   = 1;
  localparam int EVT_BOOST         = 2;
  localparam int EVT_CHARGE_TMO    = 3;
  localparam int EVT_OVERHEAT      = 4;
  localparam int EVT_FOCUS_LED     = 5;
  localparam int EVT_CHARGE_DONE   = 6;
  localparam int EVT_SELFTEST      = 7;

  // Serial slave address, value is arbitrary
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2a;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int RESET_WAIT_NS  = 4000000;
  localparam int RESET_WAIT_CYC = RESET_WAIT_NS / CLK_PERIOD_NS;
  localparam int BUSY_W         = 19;

  typedef enum logic [8:0] {
    I2C_IDLE    = 9'h001,
    I2C_ADDR    = 9'h002,
    I2C_ADDR_AK = 9'h004,
    I2C_PTR     = 9'h008,
    I2C_PTR_AK  = 9'h010,
    I2C_WR      = 9'h020,
    I2C_WR_AK   = 9'h040,
    I2C_RD      = 9'h080,
    I2C_RD_AK   = 9'h100
  } fmirq_i2c_e;

endpackage

// ---- hw/fmirq_i2c.sv ----
`timescale 1ns/1ps
`default_nettype none
module fmirq_i2c (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] rdata_i,
  output logic            sda_oe_n_o,
  output logic            wr_stb_o,
  output logic            rd_stb_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o
);
  import fmirq_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_l_q, sda_l_q;
  always_ff @(posedge clk_sys_i) begin
    scl_s_q <= {scl_s_q[0], scl_i};
    sda_s_q <= {sda_s_q[0], sda_i};
    scl_l_q <= scl_s_q[1];
    sda_l_q <= sda_s_q[1];
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s_q[1] & ~scl_l_q;
  assign scl_fall = ~scl_s_q[1] & scl_l_q;
  assign start_c  = scl_s_q[1] & scl_l_q & sda_l_q & ~sda_s_q[1];
  assign stop_c   = scl_s_q[1] & scl_l_q & ~sda_l_q & sda_s_q[1];

  // ---------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------
  fmirq_i2c_e st_q, st_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wd_q, wd_d;
  logic [3:0] cnt_q, cnt_d;
  logic       drv_q, drv_d, wr_q, wr_d, rd_q, rd_d;
  logic       oe_n_q, oe_n_d;

  always_comb begin
    st_d  = st_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    wd_d  = wd_q;
    cnt_d = cnt_q;
    drv_d = drv_q;
    wr_d  = 1'b0;
    rd_d  = 1'b0;
    if (start_c) begin
      st_d  = I2C_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_c) begin
      st_d  = I2C_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        I2C_ADDR, I2C_PTR, I2C_WR: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s_q[1]};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            if (st_q == I2C_ADDR && sh_q[7:1] != I2C_DEV_ADDR) begin
              st_d = I2C_IDLE;
            end else begin
              drv_d = 1'b1;
              if (st_q == I2C_ADDR) st_d = I2C_ADDR_AK;
              else if (st_q == I2C_PTR) st_d = I2C_PTR_AK;
              else st_d = I2C_WR_AK;
              if (st_q == I2C_PTR) ptr_d = sh_q;
              if (st_q == I2C_WR) begin
                wd_d = sh_q;
                wr_d = 1'b1;
              end
            end
          end
        end
        I2C_ADDR_AK, I2C_PTR_AK, I2C_WR_AK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            drv_d = 1'b0;
            if (st_q == I2C_WR_AK) ptr_d = ptr_q + 8'h01;
            if (st_q == I2C_ADDR_AK && sh_q[0]) begin
              // First data bit goes out on the same falling edge
              st_d  = I2C_RD;
              rd_d  = 1'b1;
              drv_d = ~rdata_i[7];
              sh_d  = {rdata_i[6:0], 1'b0};
              cnt_d = 4'h1;
              ptr_d = ptr_q + 8'h01;
            end else if (st_q == I2C_ADDR_AK) begin
              st_d = I2C_PTR;
            end else begin
              st_d = I2C_WR;
            end
          end
        end
        I2C_RD: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              st_d  = I2C_RD_AK;
              drv_d = 1'b0;
            end else begin
              drv_d = ~sh_q[7];
              sh_d  = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        I2C_RD_AK: begin
          if (scl_rise && sda_s_q[1]) begin
            st_d = I2C_IDLE;
          end else if (scl_fall) begin
            st_d  = I2C_RD;
            rd_d  = 1'b1;
            drv_d = ~rdata_i[7];
            sh_d  = {rdata_i[6:0], 1'b0};
            cnt_d = 4'h1;
            ptr_d = ptr_q + 8'h01;
          end
        end
        default: st_d = I2C_IDLE;
      endcase
    end
    // Pin enable gets its own flop so the output leaves a register directly
    oe_n_d = ~drv_d;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q  <= I2C_IDLE;
      sh_q  <= 8'h00;
      ptr_q <= 8'h00;
      wd_q  <= 8'h00;
      cnt_q <= 4'h0;
      drv_q <= 1'b0;
      oe_n_q <= 1'b1;
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      sh_q  <= sh_d;
      ptr_q <= ptr_d;
      wd_q  <= wd_d;
      cnt_q <= cnt_d;
      drv_q <= drv_d;
      oe_n_q <= oe_n_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
    end
  end

  // Read strobe carries the pointer before its increment
  logic [7:0] rd_addr_q;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) rd_addr_q <= 8'h00;
    else if (rd_d) rd_addr_q <= ptr_q;
  end

  assign sda_oe_n_o = oe_n_q;
  assign wr_stb_o   = wr_q;
  assign rd_stb_o   = rd_q;
  // Address comes from flops only, so read data never loops back into the engine
  assign addr_o     = rd_q ? rd_addr_q : ptr_q;
  assign wdata_o    = wd_q;

endmodule
`default_nettype wire

// ---- hw/fmirq_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fmirq_top #(
  parameter int unsigned RESET_WAIT_CYC = fmirq_pkg::RESET_WAIT_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] fault_evt_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic            int_o,
  output logic            int_oe_n_o,
  output logic            standby_o,
  output logic            load_defaults_o,
  output logic            soft_reset_o,
  output logic            busy_o
);
  import fmirq_pkg::*;

  // ---------------------------------------------------------------
  // Serial register port
  // ---------------------------------------------------------------
  logic       wr_stb, rd_stb;
  logic [7:0] addr, wdata, rdata;

  fmirq_i2c u_i2c (
    .clk_sys_i  (clk_sys_i),
    .srst_i     (srst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .rdata_i    (rdata),
    .sda_oe_n_o (sda_oe_n_o),
    .wr_stb_o   (wr_stb),
    .rd_stb_o   (rd_stb),
    .addr_o     (addr),
    .wdata_o    (wdata)
  );

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0]        mask_q, mask_d, pend_q, pend_d;
  logic              lp_req_q, lp_req_d, standby_q, standby_d;
  logic              ld_def_q, ld_def_d, srst_pls_q, srst_pls_d;
  logic              int_oe_n_q, int_oe_n_d;
  logic [BUSY_W-1:0] busy_q, busy_d;
  logic              wr_ok, mode_wr, stat_rd;

  // Writes are dropped while the soft reset is still being processed
  assign wr_ok   = wr_stb && (busy_q == '0);
  assign mode_wr = wr_ok && (addr == MODE_ADDR);
  assign stat_rd = rd_stb && (addr == STAT_ADDR);

  always_comb begin
    mask_d     = mask_q;
    // New events win over the clear of a status read
    pend_d     = (stat_rd ? STAT_RESET : pend_q) | fault_evt_i;
    lp_req_d   = 1'b0;
    standby_d  = standby_q;
    ld_def_d   = 1'b0;
    srst_pls_d = 1'b0;
    busy_d     = (busy_q != '0) ? busy_q - 1'b1 : busy_q;
    if (mode_wr) begin
      if (wdata[MODE_SRST_BIT]) begin
        mask_d     = MASK_RESET;
        pend_d     = STAT_RESET | fault_evt_i;
        standby_d  = 1'b0;
        srst_pls_d = 1'b1;
        busy_d     = BUSY_W'(RESET_WAIT_CYC);
      end else if (wdata[MODE_LPREQ_BIT]) begin
        lp_req_d  = 1'b1;
        ld_def_d  = 1'b1;
        standby_d = 1'b1;
      end else begin
        standby_d = 1'b0;
      end
    end else if (wr_ok && addr == MASK_ADDR) begin
      mask_d = wdata;
    end
    int_oe_n_d = ~|(pend_d & mask_d);
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mask_q     <= MASK_RESET;
      pend_q     <= STAT_RESET;
      lp_req_q   <= 1'b0;
      standby_q  <= 1'b0;
      ld_def_q   <= 1'b0;
      srst_pls_q <= 1'b0;
      int_oe_n_q <= 1'b1;
      busy_q     <= '0;
    end else begin
      mask_q     <= mask_d;
      pend_q     <= pend_d;
      lp_req_q   <= lp_req_d;
      standby_q  <= standby_d;
      ld_def_q   <= ld_def_d;
      srst_pls_q <= srst_pls_d;
      int_oe_n_q <= int_oe_n_d;
      busy_q     <= busy_d;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    if (addr == MODE_ADDR) begin
      rdata = {lp_req_q, 7'h00};
    end else if (addr == MASK_ADDR) begin
      rdata = mask_q;
    end else if (addr == STAT_ADDR) begin
      rdata = pend_q;
    end else begin
      rdata = RDATA_UNMAPPED;
    end
  end

  // ---------------------------------------------------------------
  // Pin and status outputs
  // ---------------------------------------------------------------
  logic sda_lo_q, int_lo_q, busy_o_q;
  always_ff @(posedge clk_sys_i) begin
    sda_lo_q <= 1'b0;
    int_lo_q <= 1'b0;
    if (srst_i) busy_o_q <= 1'b0;
    else busy_o_q <= (busy_d != '0);
  end

  assign sda_o           = sda_lo_q;
  assign int_o           = int_lo_q;
  assign int_oe_n_o      = int_oe_n_q;
  assign standby_o       = standby_q;
  assign load_defaults_o = ld_def_q;
  assign soft_reset_o    = srst_pls_q;
  assign busy_o          = busy_o_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  property p_rsvd_zero;
    (addr == MODE_ADDR) |-> (rdata[5:4] == 2'b00);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved mode bits not zero");

  property p_srst_reads_zero;
    (addr == MODE_ADDR) |-> !rdata[MODE_SRST_BIT];
  endproperty
  a_srst_reads_zero: assert property (p_srst_reads_zero) else $error("reset bit read one");

  property p_soft_reset;
    (mode_wr && wdata[MODE_SRST_BIT]) |=> (mask_q == MASK_RESET) && soft_reset_o
      && !standby_o ##1 !soft_reset_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied");

  property p_normal_stays;
    (!standby_o && !(mode_wr && wdata[MODE_LPREQ_BIT])) |=> !standby_o;
  endproperty
  a_normal_stays: assert property (p_normal_stays) else $error("left normal mode");

  property p_standby_req;
    (mode_wr && !wdata[MODE_SRST_BIT] && wdata[MODE_LPREQ_BIT])
      |=> load_defaults_o && standby_o && lp_req_q ##1 !lp_req_q && !load_defaults_o;
  endproperty
  a_standby_req: assert property (p_standby_req) else $error("standby request wrong");

  property p_mask_write;
    (wr_ok && addr == MASK_ADDR) |=> (mask_q == $past(wdata));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_event_enabled;
    (|(fault_evt_i & mask_d)) |=> !int_oe_n_o && (pend_q & $past(fault_evt_i))
      == $past(fault_evt_i);
  endproperty
  a_event_enabled: assert property (p_event_enabled) else $error("enabled event lost");

  property p_int_pin_low;
    int_o == 1'b0;
  endproperty
  a_int_pin_low: assert property (p_int_pin_low) else $error("interrupt pin driven high");

  property p_mask_after_reset;
    $fell(srst_i) |-> (mask_q == MASK_RESET) && int_oe_n_o;
  endproperty
  a_mask_after_reset: assert property (@(posedge clk_sys_i) p_mask_after_reset)
    else $error("mask default wrong");

  property p_status_clear;
    (stat_rd && fault_evt_i == 8'h00) |=> (pend_q == 8'h00) && int_oe_n_o;
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status read did not clear");

  property p_int_gated;
    int_oe_n_o == !(|(pend_q & mask_q));
  endproperty
  a_int_gated: assert property (p_int_gated) else $error("interrupt not gated by mask");

  c_interrupt: cover property (int_oe_n_o ##1 !int_oe_n_o);
  c_clear:     cover property (!int_oe_n_o && stat_rd ##1 int_oe_n_o);
  c_standby:   cover property (mode_wr && wdata[MODE_LPREQ_BIT] ##1 standby_o);
  c_softreset: cover property (soft_reset_o ##1 busy_o);

endmodule
`default_nettype wire

// ---- test/fmirq_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module fmirq_host
  import fmirq_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_n_o
);
  int nacks = 0;
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // Data moves two cycles after SCL falls so the synchronised pins never
  // show a false start or stop
  task automatic bit_io(input logic b, output logic s);
    hold(2);
    sda_oe_n_o = b;
    hold(6);
    scl_o = 1'b1;
    hold(4);
    s = sda_i;
    hold(4);
    scl_o = 1'b0;
  endtask
  task automatic start();
    // Wait out the slave's acknowledge before SCL rises, or a repeated
    // start would first show up as a stop
    sda_oe_n_o = 1'b1;
    hold(8);
    scl_o = 1'b1;
    hold(8);
    sda_oe_n_o = 1'b0;
    hold(8);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    hold(2);
    sda_oe_n_o = 1'b0;
    hold(6);
    scl_o = 1'b1;
    hold(8);
    sda_oe_n_o = 1'b1;
    hold(8);
  endtask
  task automatic put_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask
  task automatic get_byte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(1'b1, s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    put_byte({I2C_DEV_ADDR, 1'b0});
    put_byte(a);
    put_byte(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    put_byte({I2C_DEV_ADDR, 1'b0});
    put_byte(a);
    start();
    put_byte({I2C_DEV_ADDR, 1'b1});
    get_byte(d);
    stop();
  endtask
endmodule
`default_nettype wire

// ---- test/tb_flash_mode_and_irq_mask_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_flash_mode_and_irq_mask_regs;
  import fmirq_pkg::*;
  // ---------------------------------------------------------------
  // Bench set-up
  // ---------------------------------------------------------------
  // Host waits are scaled down with the device's busy count
  localparam int WAIT_CYC = 2000;
  localparam int STBY_GAP = 1500;
  localparam int LIMIT    = 100000;
  logic       clk_sys_i   = 1'b0;
  logic       srst_i      = 1'b1;
  logic [7:0] fault_evt_i = 8'h00;
  logic       scl, host_oe_n, sda_w, int_w;
  logic       sda_o, sda_oe_n_o, int_o, int_oe_n_o;
  logic       standby_o, load_defaults_o, soft_reset_o, busy_o;
  int         miscompares = 0;
  int         checks_done = 0;
  int         n_ld = 0;
  int         n_sr = 0;
  int         cyc = 0;
  logic [7:0] d;
  // Both lines are pulled up when nobody pulls them low
  assign sda_w = host_oe_n & (sda_oe_n_o | sda_o);
  assign int_w = int_oe_n_o | int_o;
  fmirq_top #(.RESET_WAIT_CYC(WAIT_CYC)) dut (
    .clk_sys_i      (clk_sys_i),
    .srst_i         (srst_i),
    .scl_i          (scl),
    .sda_i          (sda_w),
    .fault_evt_i    (fault_evt_i),
    .sda_o          (sda_o),
    .sda_oe_n_o     (sda_oe_n_o),
    .int_o          (int_o),
    .int_oe_n_o     (int_oe_n_o),
    .standby_o      (standby_o),
    .load_defaults_o(load_defaults_o),
    .soft_reset_o   (soft_reset_o),
    .busy_o         (busy_o)
  );
  fmirq_host host (
    .clk_sys_i (clk_sys_i),
    .sda_i     (sda_w),
    .scl_o     (scl),
    .sda_oe_n_o(host_oe_n)
  );
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (load_defaults_o === 1'b1) n_ld++;
    if (soft_reset_o === 1'b1) n_sr++;
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic fire(input logic [7:0] e);
    fault_evt_i = e;
    @(negedge clk_sys_i);
    fault_evt_i = 8'h00;
    repeat (3) @(negedge clk_sys_i);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    host.rd(MASK_ADDR, d);
    chk("mask reset", d, 8'hff);
    host.rd(MODE_ADDR, d);
    chk("mode reset", d, 8'h00);
    host.rd(8'h09, d);
    chk("unmapped", d, RDATA_UNMAPPED);
    chk("int idle", int_w, 8'h01);
  endtask
  task automatic t_mask();
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      host.wr(MASK_ADDR, m);
      host.rd(MASK_ADDR, d);
      chk("mask rw", d, m);
      fire(~m);
      chk("masked int", int_w, 8'h01);
      host.rd(STAT_ADDR, d);
      fire(m);
      chk("int low", int_w, 8'h00);
      host.rd(STAT_ADDR, d);
      chk("status bit", d, m);
      repeat (3) @(negedge clk_sys_i);
      chk("int cleared", int_w, 8'h01);
    end
  endtask
  task automatic t_mode();
    int n0;
    host.wr(MODE_ADDR, 8'h30);
    host.rd(MODE_ADDR, d);
    chk("reserved", d, 8'h00);
    n0 = n_ld;
    host.wr(MODE_ADDR, 8'h80);
    chk("defaults pulse", 8'(n_ld - n0), 8'h01);
    chk("standby", standby_o, 8'h01);
    chk("defaults low", load_defaults_o, 8'h00);
    host.rd(MODE_ADDR, d);
    chk("standby self clr", d, 8'h00);
    host.wr(MODE_ADDR, 8'h00);
    chk("normal", standby_o, 8'h00);
    host.hold(STBY_GAP);
  endtask
  task automatic t_srst();
    int n0;
    int n1;
    host.wr(MASK_ADDR, 8'h00);
    fire(8'hff);
    chk("all masked", int_w, 8'h01);
    host.wr(MASK_ADDR, 8'h0f);
    chk("unmask int", int_w, 8'h00);
    n0 = n_sr;
    host.wr(MODE_ADDR, 8'h00);
    host.rd(MASK_ADDR, d);
    chk("zero no reset", d, 8'h0f);
    host.wr(MODE_ADDR, 8'h40);
    chk("reset pulse", 8'(n_sr - n0), 8'h01);
    chk("reset low", soft_reset_o, 8'h00);
    chk("int released", int_w, 8'h01);
    host.wr(MASK_ADDR, 8'h00);
    for (int k = 0; k < WAIT_CYC + 10 && busy_o !== 1'b0; k++) host.hold(1);
    chk("busy end", busy_o, 8'h00);
    host.rd(MASK_ADDR, d);
    chk("mask default", d, 8'hff);
    host.rd(MODE_ADDR, d);
    chk("reset bit reads 0", d, 8'h00);
    // Standby, then both command bits at once: the soft reset wins
    host.wr(MASK_ADDR, 8'h00);
    host.wr(MODE_ADDR, 8'h80);
    host.hold(STBY_GAP);
    n0 = n_sr;
    n1 = n_ld;
    host.wr(MODE_ADDR, 8'hc0);
    chk("both reset", 8'(n_sr - n0), 8'h01);
    chk("both no defaults", 8'(n_ld - n1), 8'h00);
    chk("both standby", standby_o, 8'h00);
    for (int k = 0; k < WAIT_CYC + 10 && busy_o !== 1'b0; k++) host.hold(1);
    host.rd(MASK_ADDR, d);
    chk("both mask", d, 8'hff);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_i);
    srst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    t_reset();
    t_mask();
    t_mode();
    t_srst();
    chk("nacks", 8'(host.nacks), 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
